/* rtl/sctc_pkg.sv */
// package: register map, field positions and shared types of the timer
package sctc_pkg;
	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL   = 8'h00;
	localparam logic [7:0] OFS_IRQ_EN    = 8'h0c;
	localparam logic [7:0] OFS_STATUS    = 8'h10;
	localparam logic [7:0] OFS_EVENT     = 8'h14;
	localparam logic [7:0] OFS_CHAN_MODE = 8'h18;
	localparam logic [7:0] OFS_COUNT     = 8'h24;
	localparam logic [7:0] OFS_PRESCALE  = 8'h28;
	localparam logic [7:0] OFS_RELOAD    = 8'h2c;
	localparam logic [7:0] OFS_COMPARE   = 8'h34;
	localparam logic [7:0] OFS_IRQ_MASK  = 8'h40;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CR_ENABLE     = 0;
	localparam int CR_UPD_OFF    = 1;
	localparam int CR_UPD_SRC    = 2;
	localparam int CR_ONE_SHOT   = 3;
	localparam int CR_RELOAD_BUF = 7;
	localparam int CR_DIV        = 8;
	localparam int IE_UPD  = 0;
	localparam int IE_CHAN = 1;
	localparam int SR_UPD  = 0;
	localparam int SR_CHAN = 1;
	localparam int SR_OVR  = 9;
	localparam int EG_UPD  = 0;
	localparam int EG_CHAN = 1;
	localparam int CM_PRE  = 3;

	// ----------------------------------------------------------------
	// reset values and codes
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_ZERO    = 16'h0000;
	localparam logic [15:0] RST_RELOAD  = 16'hffff;
	localparam logic [1:0]  DIR_OUTPUT  = 2'h0;
	localparam logic [1:0]  DIR_INPUT   = 2'h1;
	localparam logic [15:0] CR_WMASK    = 16'h038f;
	localparam logic [15:0] IE_WMASK    = 16'h0003;
	localparam logic [15:0] SR_MASK     = 16'h0203;
	localparam logic [15:0] CM_WMASK    = 16'h000f;
	localparam logic [1:0]  AXI_OKAY    = 2'h0;
	localparam logic [1:0]  AXI_SLVERR  = 2'h2;

	typedef struct packed {
		logic [15:0] data;
		logic [1:0]  resp;
	} sctc_rd_t;
endpackage

/* rtl/sctc_timer.sv */
// single channel timer control block with an AXI4-Lite register slave
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
// What this block does
// RQ1: filter sample enable every 1, 2 or 4 clocks per division code.
// RQ2: reload limit applies at once, or at update events when buffered.
// RQ3: single pulse clears counter enable on an update event.
// RQ4: update source select leaves only overflow as an update cause.
// RQ5: update events load reload, prescaler and compare shadows.
// RQ6: with updates disabled no event; update request still resets counters.
// RQ7: counter advances only while counter enable is set.
// RQ8: interrupt forwarded only when matching enable bit is set.
// RQ9: overcapture set on capture while channel flag set; write zero clears.
// RQ10: output mode flag at compare match, or at overflow if beyond limit.
// RQ11: input capture sets channel flag; reading capture value clears it.
// RQ12: update flag on enabled overflow or enabled software update.
// RQ13: channel event request sets flag, self-clears.
// RQ14: software input event captures counter, sets flag, and overcapture if flag already set.
// RQ15: update request clears counter and prescaler, updates registers.
// RQ16: software writes 16 or 32 bits only; reads any width.
// RQ17: direction code 00 output compare, 01 input capture.
// RQ18: counter wraps to zero at reload limit, marking overflow.
module sctc_timer
	import sctc_pkg::*;
#(
	parameter int COUNT_W = 16
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              capture_in,
	output logic                   filter_sample_clock,
	output logic                   irq
);
	// the register map holds a 16-bit count, so no other width is served
	if (COUNT_W != 16) begin : g_width_check
		$error("sctc_timer: COUNT_W must be 16");
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [15:0] ctrl_q, ie_q, sr_q, cm_q, mask_q;
	logic [15:0] count_value_q, prescale_count_q;
	logic [15:0] prescale_pre_q, prescale_act_q;
	logic [15:0] limit_pre_q, limit_act_q;
	logic [15:0] ccr_pre_q, ccr_act_q;
	logic [1:0]  div_count_q;
	logic        sample_pulse_q;
	logic [2:0]  cap_sync_q;
	logic        cap_prev_q;
	logic        cap_evt;
	logic        awready_q, wready_q, arready_q;

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	logic       aw_held_q, w_held_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic       bvalid_q;
	logic [1:0] bresp_q;

	wire aw_take = s_axi_awvalid && !aw_held_q && !bvalid_q;
	wire w_take  = s_axi_wvalid && !w_held_q && !bvalid_q;
	wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
	wire [7:0] wa = {aw_addr_q[7:2], 2'b00};
	// only lower half-word or full-word writes land
	wire wr_size_ok = (w_strb_q == 4'hf) || (w_strb_q == 4'h3) ||
		(w_strb_q == 4'hc); // RQ16
	wire wr_lo = w_strb_q[1:0] == 2'h3;
	wire wr_ok = wr_fire && wr_size_ok && wr_lo;
	wire [15:0] wd = w_data_q[15:0];
	wire wr_known = (wa == OFS_CONTROL) || (wa == OFS_IRQ_EN) ||
		(wa == OFS_STATUS) || (wa == OFS_EVENT) ||
		(wa == OFS_CHAN_MODE) || (wa == OFS_COUNT) ||
		(wa == OFS_PRESCALE) || (wa == OFS_RELOAD) ||
		(wa == OFS_COMPARE) || (wa == OFS_IRQ_MASK);
	wire wr_ctrl  = wr_ok && wa == OFS_CONTROL;
	wire wr_ie    = wr_ok && wa == OFS_IRQ_EN;
	wire wr_sr    = wr_ok && wa == OFS_STATUS;
	wire wr_eg    = wr_ok && wa == OFS_EVENT;
	wire wr_cm    = wr_ok && wa == OFS_CHAN_MODE;
	wire wr_count    = wr_ok && wa == OFS_COUNT;
	wire wr_prescale = wr_ok && wa == OFS_PRESCALE;
	wire wr_limit    = wr_ok && wa == OFS_RELOAD;
	wire wr_ccr   = wr_ok && wa == OFS_COMPARE;
	wire wr_mask  = wr_ok && wa == OFS_IRQ_MASK;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= AXI_OKAY;
		end else begin
			if (aw_take) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_known ? AXI_OKAY : AXI_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end
	// readies are registered copies of the next holding state
	wire aw_held_d = !wr_fire && (aw_held_q || aw_take);
	wire w_held_d  = !wr_fire && (w_held_q || w_take);
	wire bvalid_d  = wr_fire || (bvalid_q && !s_axi_bready);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
		end else begin
			awready_q <= !aw_held_d && !bvalid_d;
			wready_q  <= !w_held_d && !bvalid_d;
		end
	end
	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;

	// ----------------------------------------------------------------
	// control decode
	// ----------------------------------------------------------------
	wire       counter_enable        = ctrl_q[CR_ENABLE];
	wire       update_disable        = ctrl_q[CR_UPD_OFF];
	wire       update_source_select  = ctrl_q[CR_UPD_SRC];
	wire       single_pulse          = ctrl_q[CR_ONE_SHOT];
	wire       reload_buffer_enable  = ctrl_q[CR_RELOAD_BUF];
	wire [1:0] filter_clock_division = ctrl_q[CR_DIV +: 2];
	wire [1:0] dir                   = cm_q[1:0];
	wire       ccr_buf               = cm_q[CM_PRE];
	wire       is_out                = dir == DIR_OUTPUT; // RQ17
	wire       is_in                 = dir == DIR_INPUT; // RQ17
	wire       update_request        = wr_eg && wd[EG_UPD]; // RQ15
	wire       cg_req                = wr_eg && wd[EG_CHAN]; // RQ13

	// ----------------------------------------------------------------
	// prescaler and counter
	// ----------------------------------------------------------------
	wire prescale_tick = counter_enable &&
		(prescale_count_q == prescale_act_q); // RQ7
	wire overflow = prescale_tick &&
		(count_value_q >= limit_act_q); // RQ18
	// overflow is an update cause under both source settings
	wire upd_cause = overflow ||
		(update_request && !update_source_select); // RQ4
	wire update_event = upd_cause && !update_disable; // RQ6
	wire shadow_load = update_event; // RQ5
	wire [15:0] count_next = overflow ? RST_ZERO :
		count_value_q + 16'h0001; // RQ18

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_value_q    <= RST_ZERO;
			prescale_count_q <= RST_ZERO;
		end else if (update_request) begin
			// software update restarts counting even while disabled
			count_value_q    <= RST_ZERO; // RQ15
			prescale_count_q <= RST_ZERO; // RQ6
		end else if (wr_count) begin
			count_value_q <= wd;
		end else if (counter_enable) begin
			prescale_count_q <= prescale_tick ? RST_ZERO :
				prescale_count_q + 16'h0001;
			if (prescale_tick)
				count_value_q <= count_next; // RQ7
		end
	end

	// ----------------------------------------------------------------
	// preload and shadow registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			limit_pre_q    <= RST_RELOAD;
			limit_act_q    <= RST_RELOAD;
			prescale_pre_q <= RST_ZERO;
			prescale_act_q <= RST_ZERO;
			ccr_pre_q      <= RST_ZERO;
			ccr_act_q      <= RST_ZERO;
		end else begin
			if (wr_limit)
				limit_pre_q <= wd;
			if (wr_prescale)
				prescale_pre_q <= wd;
			if (wr_ccr && is_out)
				ccr_pre_q <= wd;
			if (wr_limit && !reload_buffer_enable)
				limit_act_q <= wd; // RQ2
			else if (shadow_load && reload_buffer_enable)
				limit_act_q <= limit_pre_q; // RQ2
			if (shadow_load)
				prescale_act_q <= prescale_pre_q; // RQ5
			if (cap_evt)
				ccr_act_q <= count_value_q; // RQ14
			else if (wr_ccr && is_out && !ccr_buf)
				ccr_act_q <= wd;
			else if (shadow_load && is_out && ccr_buf)
				ccr_act_q <= ccr_pre_q; // RQ5
		end
	end

	// ----------------------------------------------------------------
	// filter sample clock and capture input
	// ----------------------------------------------------------------
	wire [1:0] div_last = (filter_clock_division == 2'h0) ? 2'h0 :
		(filter_clock_division == 2'h1) ? 2'h1 : 2'h3; // RQ1
	wire sample_tick = (div_count_q >= div_last); // RQ1
	wire edge_ok = cap_sync_q[2] == cap_sync_q[1];
	wire pin_rise = edge_ok && cap_sync_q[2] && !cap_prev_q;
	wire hw_cap = is_in && pin_rise;
	assign cap_evt = is_in && (hw_cap || cg_req); // RQ14
	wire cmp_hit = is_out && prescale_tick && (
		(count_value_q == ccr_act_q) ||
		(overflow && ccr_act_q > limit_act_q)); // RQ10

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_count_q    <= 2'h0;
			sample_pulse_q <= 1'b0;
			cap_sync_q     <= 3'h0;
			cap_prev_q     <= 1'b0;
		end else begin
			div_count_q    <= sample_tick ? 2'h0 : div_count_q + 2'h1;
			sample_pulse_q <= sample_tick; // RQ1
			cap_sync_q     <= {cap_sync_q[1:0], capture_in};
			if (edge_ok)
				cap_prev_q <= cap_sync_q[2];
		end
	end
	assign filter_sample_clock = sample_pulse_q;

	// ----------------------------------------------------------------
	// read side
	// ----------------------------------------------------------------
	logic       rvalid_q;
	sctc_rd_t   rd_q;
	wire [7:0]  ra = {s_axi_araddr[7:2], 2'b00};
	wire        ar_take = s_axi_arvalid && !rvalid_q;
	wire        rd_ccr = ar_take && ra == OFS_COMPARE && is_in; // RQ11
	sctc_rd_t   rd_d;
	assign rd_d.resp =
		(ra == OFS_CONTROL || ra == OFS_IRQ_EN || ra == OFS_STATUS ||
		ra == OFS_EVENT || ra == OFS_CHAN_MODE || ra == OFS_COUNT ||
		ra == OFS_PRESCALE || ra == OFS_RELOAD || ra == OFS_COMPARE ||
		ra == OFS_IRQ_MASK) ? AXI_OKAY : AXI_SLVERR;
	assign rd_d.data =
		(ra == OFS_CONTROL)   ? ctrl_q :
		(ra == OFS_IRQ_EN)    ? ie_q :
		(ra == OFS_STATUS)    ? sr_q :
		(ra == OFS_CHAN_MODE) ? cm_q :
		(ra == OFS_COUNT)     ? count_value_q :
		(ra == OFS_PRESCALE)  ? prescale_pre_q :
		(ra == OFS_RELOAD)    ? (reload_buffer_enable ? limit_pre_q :
			limit_act_q) :
		(ra == OFS_COMPARE)   ? (is_out && ccr_buf ? ccr_pre_q :
			ccr_act_q) :
		(ra == OFS_IRQ_MASK)  ? mask_q : RST_ZERO;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rd_q     <= '0;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rd_q     <= rd_d;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
	// arready is the registered copy of the next idle read state
	always_ff @(posedge aclk) begin
		if (!aresetn)
			arready_q <= 1'b1;
		else
			arready_q <= !(ar_take || (rvalid_q && !s_axi_rready));
	end
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = {16'h0000, rd_q.data};
	assign s_axi_rresp   = rd_q.resp;

	// ----------------------------------------------------------------
	// control, status and interrupt
	// ----------------------------------------------------------------
	wire set_upd  = update_event; // RQ12
	wire set_chan = cap_evt || cmp_hit || (cg_req && is_out); // RQ13
	wire set_ovr  = cap_evt && sr_q[SR_CHAN]; // RQ9
	// write-zero clear; a set in the same cycle wins
	wire [15:0] keep = wr_sr ? (wd & SR_MASK) : SR_MASK;
	wire clr_chan = !keep[SR_CHAN] || rd_ccr; // RQ11
	logic [15:0] sr_d;
	always_comb begin
		sr_d = sr_q;
		sr_d[SR_UPD]  = set_upd  || (sr_q[SR_UPD] && keep[SR_UPD]);
		sr_d[SR_CHAN] = set_chan || (sr_q[SR_CHAN] && !clr_chan);
		sr_d[SR_OVR]  = set_ovr  || (sr_q[SR_OVR] && keep[SR_OVR]); // RQ9
	end
	wire irq_d = |(sr_q & ie_q & mask_q); // RQ8

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= RST_ZERO;
			ie_q   <= RST_ZERO;
			sr_q   <= RST_ZERO;
			cm_q   <= RST_ZERO;
			mask_q <= SR_MASK;
			irq    <= 1'b0;
		end else begin
			if (wr_ctrl)
				ctrl_q <= wd & CR_WMASK;
			else if (update_event && single_pulse)
				ctrl_q[CR_ENABLE] <= 1'b0; // RQ3
			if (wr_ie)
				ie_q <= wd & IE_WMASK;
			if (wr_cm)
				cm_q <= wd & CM_WMASK;
			if (wr_mask)
				mask_q <= wd & SR_MASK;
			sr_q <= sr_d;
			irq  <= irq_d;
		end
	end
endmodule

/* bench/sctc_checker.sv */
// concurrent checks on the timer's bus and pins
`timescale 1ns/100ps
module sctc_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        filter_sample_clock
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_r_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_answer: assert property (p_r_answer) else $error("read answer late");
	property p_b_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##[1:2] s_axi_bvalid;
	endproperty
	a_b_answer: assert property (p_b_answer) else $error("write answer late");
	property p_refuse;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_refuse: assert property (p_refuse) else $error("write taken while busy");
	property p_r_done;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
	endproperty
	a_r_done: assert property (p_r_done) else $error("read answer stuck");
	property p_upper;
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
	endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	property p_fsc;
		// slowest division is four clocks, so a pulse is never further off
		1'b1 |-> ##[0:4] filter_sample_clock;
	endproperty
	a_fsc: assert property (p_fsc) else $error("sample pulse missing");
endmodule

/* bench/tb_top.sv */
// register level bench of the timer control block
`timescale 1ns/100ps
module tb_top;
	import sctc_pkg::*;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, fsc, irq, cap;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d, pulses;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	int          errors, n_checks, c;
	sctc_timer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .capture_in(cap),
		.filter_sample_clock(fsc), .irq(irq));
	initial begin
		aclk = 0;
		forever #25 aclk = ~aclk;
	end
	// ----------------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------------
	task conclude;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
		n_checks++;
		if (seen !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, seen);
		end
	endtask
	// ready is raised late on purpose so the slave must hold its answer
	task wr(input logic [7:0] a, input logic [15:0] v, input logic [3:0] s);
		logic ah, wh, bh, fin;
		fin = 0;
		@(posedge aclk);
		{awaddr, wdata, wstrb} <= {a, 16'h0000, v, s};
		{awvalid, wvalid} <= 2'b11;
		for (int i = 0; i < 40 && !fin; i++) begin
			@(negedge aclk);
			ah = awvalid & awready;
			wh = wvalid & wready;
			bh = bvalid & bready;
			if (bh) r = bresp;
			@(posedge aclk);
			if (ah) awvalid <= 0;
			if (wh) wvalid <= 0;
			if (i == 2) bready <= 1;
			if (bh) begin
				bready <= 0;
				fin = 1;
			end
		end
		if (!fin) begin
			errors++;
			conclude();
		end
	endtask
	task rd(input logic [7:0] a);
		logic ah, rh, fin;
		fin = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		for (int i = 0; i < 40 && !fin; i++) begin
			@(negedge aclk);
			ah = arvalid & arready;
			rh = rvalid & rready;
			if (rh) {d, r} = {rdata, rresp};
			@(posedge aclk);
			if (ah) arvalid <= 0;
			if (i == 2) rready <= 1;
			if (rh) begin
				rready <= 0;
				fin = 1;
			end
		end
		if (!fin) begin
			errors++;
			conclude();
		end
	endtask
	task rc(input logic [7:0] a, input logic [15:0] e);
		rd(a);
		chk($sformatf("reg %h", a), d, {16'h0000, e});
		chk("rresp", 32'(r), 32'(AXI_OKAY));
	endtask
	task w(input logic [7:0] a, input logic [15:0] v);
		wr(a, v, 4'hf);
	endtask
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, cap} = 7'h00;
		{awaddr, araddr, wdata, wstrb} = '0;
		errors = 0;
		n_checks = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		rc(OFS_CONTROL, RST_ZERO);
		rc(OFS_IRQ_EN, RST_ZERO);
		rc(OFS_STATUS, RST_ZERO);
		rc(OFS_EVENT, RST_ZERO);
		rc(OFS_RELOAD, RST_RELOAD);
		rd(8'h1c);
		chk("unmapped resp", 32'(r), 32'(AXI_SLVERR));
		w(8'h1c, 16'h0001);
		chk("unmapped bresp", 32'(r), 32'(AXI_SLVERR));
		$display("test reset done");
		for (c = 0; c < 3; c++) begin
			w(OFS_CONTROL, 16'(c << CR_DIV));
			repeat (6) @(negedge aclk);
			pulses = 0;
			repeat (8) @(negedge aclk) pulses = pulses + {31'h0, fsc};
			chk("sample pulses", pulses, 32'(8 >> c));
		end
		$display("test division done");
		w(OFS_COUNT, 16'h0005);
		w(OFS_CONTROL, 16'h0002);
		w(OFS_EVENT, 16'h0001);
		rc(OFS_COUNT, 16'h0000);
		rc(OFS_STATUS, 16'h0000);
		w(OFS_CONTROL, 16'h0004);
		w(OFS_EVENT, 16'h0001);
		rc(OFS_STATUS, 16'h0000);
		w(OFS_CONTROL, 16'h0000);
		w(OFS_COUNT, 16'h0005);
		w(OFS_EVENT, 16'h0001);
		rc(OFS_COUNT, 16'h0000);
		rc(OFS_STATUS, 16'h0001);
		w(OFS_IRQ_EN, 16'h0001);
		repeat (3) @(negedge aclk);
		chk("irq", 32'(irq), 32'h1);
		w(OFS_IRQ_EN, 16'h0002);
		repeat (3) @(negedge aclk);
		chk("irq", 32'(irq), 32'h0);
		w(OFS_STATUS, 16'h0000);
		rc(OFS_STATUS, 16'h0000);
		$display("test update done");
		w(OFS_RELOAD, 16'h0003);
		w(OFS_COMPARE, 16'h0002);
		w(OFS_CONTROL, 16'h0009);
		repeat (30) @(negedge aclk);
		rc(OFS_CONTROL, 16'h0008);
		rc(OFS_STATUS, 16'h0003);
		rc(OFS_COUNT, 16'h0000);
		chk("irq", 32'(irq), 32'h1);
		wr(OFS_CONTROL, 16'h0001, 4'h1);
		chk("bresp", 32'(r), 32'(AXI_OKAY));
		rc(OFS_CONTROL, 16'h0008);
		rc(OFS_COUNT, 16'h0000);
		$display("test single pulse done");
		// slow prescale waits in the preload until an update event
		w(OFS_STATUS, 16'h0000);
		w(OFS_CONTROL, 16'h0080);
		w(OFS_PRESCALE, 16'h0063);
		w(OFS_RELOAD, 16'h0009);
		rc(OFS_RELOAD, 16'h0009);
		w(OFS_CONTROL, 16'h0082);
		w(OFS_EVENT, 16'h0001);
		w(OFS_COUNT, 16'h0003);
		w(OFS_CONTROL, 16'h0081);
		rc(OFS_COUNT, 16'h0000);
		w(OFS_CONTROL, 16'h0080);
		rc(OFS_STATUS, 16'h0001);
		$display("test buffers done");
		w(OFS_STATUS, 16'h0000);
		w(OFS_EVENT, 16'h0002);
		rc(OFS_STATUS, 16'h0002);
		rc(OFS_EVENT, 16'h0000);
		w(OFS_COUNT, 16'h0007);
		w(OFS_CHAN_MODE, {14'h0000, DIR_INPUT});
		w(OFS_STATUS, 16'h0000);
		w(OFS_EVENT, 16'h0002);
		w(OFS_EVENT, 16'h0002);
		rc(OFS_STATUS, 16'h0202);
		rc(OFS_COMPARE, 16'h0007);
		rc(OFS_STATUS, 16'h0200);
		w(OFS_STATUS, 16'h0000);
		rc(OFS_STATUS, 16'h0000);
		w(OFS_COUNT, 16'h000b);
		@(posedge aclk);
		cap <= 1;
		repeat (6) @(negedge aclk);
		rc(OFS_STATUS, 16'h0002);
		rc(OFS_COMPARE, 16'h000b);
		$display("test channel done");
		conclude();
	end
endmodule
bind sctc_timer sctc_checker chk_i (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.filter_sample_clock(filter_sample_clock));
